// File: rtl/jack_widget_regs.sv
// verb-addressed register set of one microphone jack pin widget
//
// How it works
// (R1) capability word reports type 4 in 23:20, zero delay in 19:16
// (R2) capability: power support, event support set; no list; analog stream
// (R3) capability: input gain present and stereo; other feature bits zero
// (R4) jack capability reports bias support mask 17h in bits 15:8
// (R5) jack capability: input, presence, amp power-down set; others zero
// (R6) two-bit left and right gain set by 360h/350h, read back
// (R7) settings-lost flag set at reset, cleared by power get or any set
// (R8) power error bit set when requested state cannot be entered
// (R9) requested power state stored from verb 705h and read back
// (R10) actual power state in bits 5:4, three after reset
// (R11) pin control byte: out enable bit 6, in enable bit 5
// (R12) bias select codes; reserved codes 011b,110b,111b give no bias
// (R13) event enable bit 7 gates both event responses and wakes
// (R14) software tag placed in bits 31:26 of each event response
// (R15) presence indicator at bit 31 of sense word, rest zero
// (R16) amp power-down bit drives pin high only when widget powered
// (R17) attachment kind in bits 31:30, reset jack
// (R18) location bits 29:24 reset 04h
// (R19) descriptor resets: mic in, 1/8 inch, pink, association 2
// (R20) misc nibble bit 0 is jack-detect override, others reserved
// (R21) reserved bits read zero except misc bits 11:9, which read as written; read-only writes ignored
// (R22) descriptor resets only on power-on; rest also on group/link reset
`timescale 1ns/1ps
`default_nettype none
module jack_widget_regs
  import jack_widget_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        function_group_reset,
  input  wire logic        link_reset,
  input  wire logic        verb_valid,
  input  wire logic [19:0] verb_code,
  input  wire logic [7:0]  verb_payload,
  input  wire logic        jack_present_pin,
  output logic             resp_valid,
  output logic [31:0]      resp_data,
  output logic             event_valid,
  output logic [31:0]      event_data,
  output logic             wake_req,
  output logic             amp_powerdown_pin,
  output logic [1:0]       left_gain_out,
  output logic [1:0]       right_gain_out,
  output logic [2:0]       bias_select_out,
  output logic             receive_in_enable_out
);

  // verb decode
  function automatic logic is_set(input logic [19:0] code, input logic [11:0] verb);
    is_set = (code[19:8] == verb);
  endfunction : is_set

  // reserved bias codes fall back to high impedance
  function automatic logic bias_reserved(input logic [2:0] code);
    bias_reserved = (code == 3'h3) || (code[2:1] == 2'h3);
  endfunction : bias_reserved

  logic        set_any;
  logic        get_power;
  logic        soft_rst;
  logic        link_sync_q, link_sync2_q;
  logic        fg_sync_q, fg_sync2_q;
  logic        pres_sync_q, pres_sync2_q, pres_prev_q;
  logic [1:0]  left_gain_q, right_gain_q;
  logic [1:0]  power_set_q, power_act_q;
  logic        power_move_q;
  logic        presence_seen;
  logic        pres_change;
  logic        power_err_q, settings_lost_q;
  logic        out_en_q, in_en_q;
  logic [2:0]  bias_select_q;
  logic        event_en_q;
  logic [5:0]  event_tag_q;
  logic        amp_pd_q;
  logic [31:0] descriptor_q;
  logic [31:0] read_d;

  // resets arrive from outside the clock domain
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      link_sync_q  <= 1'b0;
      link_sync2_q <= 1'b0;
      fg_sync_q    <= 1'b0;
      fg_sync2_q   <= 1'b0;
    end
    else
    begin
      link_sync_q  <= link_reset;
      link_sync2_q <= link_sync_q;
      fg_sync_q    <= function_group_reset;
      fg_sync2_q   <= fg_sync_q;
    end
  end

  // presence pin synchroniser and edge history
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pres_sync_q  <= 1'b0;
      pres_sync2_q <= 1'b0;
      pres_prev_q  <= 1'b0;
    end
    else
    begin
      pres_sync_q  <= jack_present_pin;
      pres_sync2_q <= pres_sync_q;
      pres_prev_q  <= pres_sync2_q;
    end
  end

  assign soft_rst  = fg_sync2_q | link_sync2_q;
  assign set_any   = verb_valid & (verb_code[19:16] != 4'hf) & (verb_code[19:16] != 4'hb);
  assign get_power = verb_valid & (verb_code == POWER_STATE_WORD);
  // override flag masks the jack sense and its events
  assign presence_seen = pres_sync2_q & ~descriptor_q[OVERRIDE_BIT];  // see (R20)
  assign pres_change   = (pres_sync2_q ^ pres_prev_q) & ~descriptor_q[OVERRIDE_BIT];  // see (R20)

  // gain steps
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || soft_rst)
    begin
      left_gain_q  <= 2'h0;
      right_gain_q <= 2'h0;
    end
    else if (verb_valid)
    begin
      if (is_set(verb_code, VERB_SET_GAIN_LEFT))
        left_gain_q <= verb_payload[1:0];  // see (R6)
      if (is_set(verb_code, VERB_SET_GAIN_RIGHT))
        right_gain_q <= verb_payload[1:0];  // see (R6)
    end
  end

  // power state; all four states reachable, so error stays clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || soft_rst)
    begin
      power_set_q <= POWER_SET_RST;
      power_act_q <= POWER_ACT_RST;  // see (R10)
      power_err_q <= 1'b0;
      power_move_q <= 1'b0;
    end
    else
    begin
      if (verb_valid && is_set(verb_code, VERB_SET_POWER))
        power_set_q <= verb_payload[1:0];  // see (R9)
      // actual state moves one cycle after a power write, so it reads 3 after reset
      power_move_q <= verb_valid && is_set(verb_code, VERB_SET_POWER);
      if (power_move_q)
        power_act_q <= power_set_q;  // see (R10)
      power_err_q <= 1'b0;  // see (R8)
    end
  end

  // settings-lost flag
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || soft_rst)
      settings_lost_q <= 1'b1;  // see (R7)
    else if (set_any || get_power)
      settings_lost_q <= 1'b0;  // see (R7)
  end

  // pin control and event control
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || soft_rst)
    begin
      out_en_q      <= 1'b0;
      in_en_q       <= 1'b0;
      bias_select_q <= 3'h0;
      event_en_q    <= 1'b0;
      event_tag_q   <= 6'h00;
      amp_pd_q      <= AMP_PD_RST;
    end
    else if (verb_valid)
    begin
      if (is_set(verb_code, VERB_SET_JACK_CTRL))
      begin
        out_en_q      <= verb_payload[OUT_EN_BIT];  // see (R11)
        in_en_q       <= verb_payload[IN_EN_BIT];  // see (R11)
        bias_select_q <= verb_payload[2:0];
      end
      if (is_set(verb_code, VERB_SET_EVENT_CTRL))
      begin
        event_en_q  <= verb_payload[EVENT_EN_BIT];
        event_tag_q <= verb_payload[5:0];  // see (R14)
      end
      if (is_set(verb_code, VERB_SET_AMP_PD))
        amp_pd_q <= verb_payload[AMP_PD_BIT];  // see (R16)
    end
  end

  // descriptor, power-on reset only
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      descriptor_q <= DESCRIPTOR_RST;  // see (R17) (R18) (R19) (R22)
    else if (verb_valid)
    begin
      if (is_set(verb_code, VERB_SET_DESC_B0))
        descriptor_q[7:0] <= verb_payload;
      if (is_set(verb_code, VERB_SET_DESC_B1))
        descriptor_q[15:8] <= verb_payload;  // see (R20)
      if (is_set(verb_code, VERB_SET_DESC_B2))
        descriptor_q[23:16] <= verb_payload;
      if (is_set(verb_code, VERB_SET_DESC_B3))
        descriptor_q[31:24] <= verb_payload;
    end
  end

  // read mux
  always_comb
  begin
    read_d = 32'h0;  // see (R21)
    case (verb_code)
      WIDGET_CAPABILITY_WORD: read_d = WIDGET_CAP_VALUE;  // see (R1) (R2) (R3)
      JACK_CAPABILITY_WORD:   read_d = JACK_CAP_VALUE;  // see (R4) (R5)
      LEFT_INPUT_GAIN:        read_d = {30'h0, left_gain_q};
      RIGHT_INPUT_GAIN:       read_d = {30'h0, right_gain_q};
      POWER_STATE_WORD:
        read_d = {21'h0, settings_lost_q, 1'b0, power_err_q, 2'h0,
                  power_act_q, 2'h0, power_set_q};
      JACK_CONTROL_WORD:
        read_d = {25'h0, out_en_q, in_en_q, 2'h0, bias_select_q};
      EVENT_REPORT_CONTROL:   read_d = {24'h0, event_en_q, 1'b0, event_tag_q};
      JACK_PRESENCE_SENSE:    read_d = {presence_seen, 31'h0};  // see (R15) (R20)
      AMP_POWERDOWN_CONTROL:  read_d = {30'h0, amp_pd_q, 1'b0};
      JACK_DESCRIPTOR, JACK_DESCRIPTOR_B1, JACK_DESCRIPTOR_B2, JACK_DESCRIPTOR_B3:
        read_d = descriptor_q;
      default:                read_d = 32'h0;
    endcase
  end

  // response register, one cycle after each verb
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      resp_valid <= 1'b0;
      resp_data  <= 32'h0;
    end
    else
    begin
      resp_valid <= verb_valid;
      resp_data  <= verb_valid ? read_d : 32'h0;
    end
  end

  // event response and wake on presence change
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      event_valid <= 1'b0;
      event_data  <= 32'h0;
      wake_req    <= 1'b0;
    end
    else
    begin
      event_valid <= event_en_q && pres_change;  // see (R13)
      wake_req    <= event_en_q && pres_change
                     && (power_act_q != POWER_D0);  // see (R13)
      event_data  <= {event_tag_q, 26'h0};  // see (R14)
    end
  end

  // analog side controls
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      amp_powerdown_pin     <= 1'b0;
      left_gain_out         <= 2'h0;
      right_gain_out        <= 2'h0;
      bias_select_out       <= 3'h0;
      receive_in_enable_out <= 1'b0;
    end
    else
    begin
      amp_powerdown_pin <= amp_pd_q && (power_act_q == POWER_D0);  // see (R16)
      left_gain_out     <= left_gain_q;
      right_gain_out    <= right_gain_q;
      // reserved codes give high impedance
      bias_select_out   <= bias_reserved(bias_select_q) ? 3'h0 : bias_select_q;  // see (R12)
      receive_in_enable_out <= in_en_q;
    end
  end

  // steps of a power write and of a pin control write
  sequence seq_power_write;
    verb_valid && is_set(verb_code, VERB_SET_POWER);
  endsequence
  sequence seq_jack_write;
    verb_valid && is_set(verb_code, VERB_SET_JACK_CTRL);
  endsequence
  sequence seq_settled;
    !soft_rst;
  endsequence
  // settings-lost flag
  AST_LOST_AFTER_GET: assert property (@(posedge ref_clk)  // see (R7)
    disable iff (!resetn)
    get_power && !soft_rst |=> !settings_lost_q)
    else $error("settings-lost flag not cleared");
  AST_LOST_AFTER_SET: assert property (@(posedge ref_clk)  // see (R7)
    disable iff (!resetn)
    set_any && !soft_rst |=> !settings_lost_q)
    else $error("settings-lost flag not cleared by set");
  AST_LOST_ON_RESET: assert property (@(posedge ref_clk)  // see (R7)
    disable iff (!resetn)
    soft_rst |=> settings_lost_q)
    else $error("settings-lost flag not raised");
  // power state
  AST_ERR_CLEAR: assert property (@(posedge ref_clk)  // see (R8)
    disable iff (!resetn)
    !power_err_q)
    else $error("power error asserted");
  AST_SET_STORED: assert property (@(posedge ref_clk)  // see (R9)
    disable iff (!resetn || soft_rst)
    seq_power_write |=> power_set_q == $past(verb_payload[1:0]))
    else $error("power setting not stored");
  AST_ACT_FOLLOWS: assert property (@(posedge ref_clk)  // see (R10)
    disable iff (!resetn || soft_rst)
    seq_power_write ##1 seq_settled |=> power_act_q == $past(verb_payload[1:0], 2))
    else $error("actual power state not reached");
  AST_ACT_ON_RESET: assert property (@(posedge ref_clk)  // see (R10)
    disable iff (!resetn)
    soft_rst |=> power_act_q == POWER_ACT_RST)
    else $error("actual power state not restored");
  // gains and pin control
  AST_GAIN_L: assert property (@(posedge ref_clk)  // see (R6)
    disable iff (!resetn || soft_rst)
    verb_valid && is_set(verb_code, VERB_SET_GAIN_LEFT) |=> left_gain_q == $past(verb_payload[1:0]))
    else $error("left gain not stored");
  AST_IN_ENABLE: assert property (@(posedge ref_clk)  // see (R11)
    disable iff (!resetn || soft_rst)
    seq_jack_write ##1 seq_settled |=> receive_in_enable_out == $past(verb_payload[IN_EN_BIT], 2))
    else $error("input enable not applied");
  AST_BIAS_FOLLOWS: assert property (@(posedge ref_clk)  // see (R12)
    disable iff (!resetn || soft_rst)
    seq_jack_write ##1 seq_settled |=> bias_select_out ==
      (($past(verb_payload[2:0], 2) inside {3'h3, 3'h6, 3'h7})
        ? 3'h0 : $past(verb_payload[2:0], 2)))
    else $error("bias select not applied");
  // events
  AST_NO_EVENT_OFF: assert property (@(posedge ref_clk)  // see (R13)
    disable iff (!resetn)
    !$past(event_en_q) |-> !event_valid && !wake_req)
    else $error("event while disabled");
  AST_WAKE_POWERED: assert property (@(posedge ref_clk)  // see (R13)
    disable iff (!resetn)
    wake_req |-> $past(power_act_q) != POWER_D0)
    else $error("wake while widget active");
  AST_TAG: assert property (@(posedge ref_clk)  // see (R14)
    disable iff (!resetn)
    event_valid |-> event_data[31:TAG_LSB] == $past(event_tag_q))
    else $error("tag missing");
  AST_OVERRIDE_QUIET: assert property (@(posedge ref_clk)  // see (R20)
    disable iff (!resetn)
    descriptor_q[OVERRIDE_BIT] |=> !event_valid)
    else $error("event while jack detect overridden");
  // read words and pins
  AST_CAP_WORD: assert property (@(posedge ref_clk)  // see (R1)
    disable iff (!resetn)
    verb_valid && verb_code == WIDGET_CAPABILITY_WORD |=> resp_data == WIDGET_CAP_VALUE)
    else $error("capability word wrong");
  AST_SENSE: assert property (@(posedge ref_clk)  // see (R15)
    disable iff (!resetn)
    verb_valid && verb_code == JACK_PRESENCE_SENSE |=> resp_data[30:0] == 31'h0)
    else $error("sense reserved bits set");
  AST_AMP_PIN: assert property (@(posedge ref_clk)  // see (R16)
    disable iff (!resetn)
    amp_powerdown_pin |-> $past(amp_pd_q) && $past(power_act_q) == POWER_D0)
    else $error("amp pin high while unpowered");
  AST_DESC_KEEP: assert property (@(posedge ref_clk)  // see (R22)
    disable iff (!resetn)
    soft_rst && !verb_valid |=> $stable(descriptor_q))
    else $error("descriptor changed by soft reset");
endmodule : jack_widget_regs
`default_nettype wire

// File: rtl/jack_widget_pkg.sv
// constants for the microphone jack widget register set
`default_nettype none
package jack_widget_pkg;
  // verb codes: 12-bit set verbs carry 8-bit payload, 20-bit get verbs
  localparam logic [11:0] VERB_SET_GAIN_LEFT   = 12'h360;
  localparam logic [11:0] VERB_SET_GAIN_RIGHT  = 12'h350;
  localparam logic [11:0] VERB_SET_POWER       = 12'h705;
  localparam logic [11:0] VERB_SET_JACK_CTRL   = 12'h707;
  localparam logic [11:0] VERB_SET_EVENT_CTRL  = 12'h708;
  localparam logic [11:0] VERB_SET_AMP_PD      = 12'h70c;
  localparam logic [11:0] VERB_SET_DESC_B0     = 12'h71c;
  localparam logic [11:0] VERB_SET_DESC_B1     = 12'h71d;
  localparam logic [11:0] VERB_SET_DESC_B2     = 12'h71e;
  localparam logic [11:0] VERB_SET_DESC_B3     = 12'h71f;
  // get offsets from the register table
  localparam logic [19:0] RIGHT_INPUT_GAIN       = 20'hb0000;
  localparam logic [19:0] LEFT_INPUT_GAIN        = 20'hb2000;
  localparam logic [19:0] WIDGET_CAPABILITY_WORD = 20'hf0009;
  localparam logic [19:0] JACK_CAPABILITY_WORD   = 20'hf000c;
  localparam logic [19:0] POWER_STATE_WORD       = 20'hf0500;
  localparam logic [19:0] JACK_CONTROL_WORD      = 20'hf0700;
  localparam logic [19:0] EVENT_REPORT_CONTROL   = 20'hf0800;
  localparam logic [19:0] JACK_PRESENCE_SENSE    = 20'hf0900;
  localparam logic [19:0] AMP_POWERDOWN_CONTROL  = 20'hf0c00;
  localparam logic [19:0] JACK_DESCRIPTOR        = 20'hf1c00;
  localparam logic [19:0] JACK_DESCRIPTOR_B1     = 20'hf1d00;
  localparam logic [19:0] JACK_DESCRIPTOR_B2     = 20'hf1e00;
  localparam logic [19:0] JACK_DESCRIPTOR_B3     = 20'hf1f00;
  // hard-coded capability words
  localparam logic [31:0] WIDGET_CAP_VALUE = 32'h00400483;
  localparam logic [7:0]  BIAS_SUPPORT_MASK = 8'h17;
  localparam logic [31:0] JACK_CAP_VALUE   = {15'h0000, 1'b1, BIAS_SUPPORT_MASK, 8'h24};
  // reset values
  localparam logic [1:0]  POWER_SET_RST  = 2'h0;
  localparam logic [1:0]  POWER_ACT_RST  = 2'h3;
  localparam logic [1:0]  POWER_D0       = 2'h0;
  localparam logic        AMP_PD_RST     = 1'b1;
  localparam logic [31:0] DESCRIPTOR_RST = 32'h04a19020;
  // field positions
  localparam int SETTINGS_LOST_BIT = 10;
  localparam int POWER_ERROR_BIT   = 8;
  localparam int OUT_EN_BIT        = 6;
  localparam int IN_EN_BIT         = 5;
  localparam int EVENT_EN_BIT      = 7;
  localparam int AMP_PD_BIT        = 1;
  localparam int PRESENCE_BIT      = 31;
  localparam int TAG_LSB           = 26;
  localparam int OVERRIDE_BIT      = 8;
endpackage : jack_widget_pkg
`default_nettype wire

// File: testbench/link_ctrl_model.sv
// controller-side model that issues get and set verbs to the jack widget
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model (
  input  wire logic        clk,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_data,
  output var logic         verb_valid,
  output var logic  [19:0] verb_code,
  output var logic  [7:0]  verb_payload
);
  int unsigned spacing = 0; // idle cycles before each verb, for slow pacing
  initial
  begin
    verb_valid   = 1'b0;
    verb_code    = 20'h00000;
    verb_payload = 8'h00;
  end
  // one verb for one cycle, then a bounded wait for its answer
  task automatic xfer(input logic [19:0] code, input logic [7:0] pay,
                      output logic [31:0] data);
    data = 'x;
    repeat (spacing) @(posedge clk);
    @(posedge clk);
    verb_valid   <= 1'b1;
    verb_code    <= code;
    verb_payload <= pay;
    @(posedge clk);
    verb_valid   <= 1'b0;
    verb_code    <= ~code; // released lines show no stale value
    verb_payload <= ~pay;
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if (resp_valid === 1'b1)
      begin
        data = resp_data;
        break;
      end
      @(posedge clk);
    end
  endtask : xfer
endmodule : link_ctrl_model
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the jack widget register set
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("mismatch t=%0t got %h want %h", $time, got, exp); \
    end \
  end
module tb_top
  import jack_widget_pkg::*;
;
  localparam logic [31:0] DESC_EXP = {2'h0, 6'h04, 4'ha, 4'h1, 4'h9, 4'h0, 4'h2, 4'h0};
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        function_group_reset = 1'b0;
  logic        link_reset = 1'b0;
  logic        jack_present_pin = 1'b0;
  logic        verb_valid, resp_valid, event_valid, wake_req;
  logic        amp_powerdown_pin, receive_in_enable_out;
  logic [19:0] verb_code;
  logic [7:0]  verb_payload;
  logic [31:0] resp_data, event_data, d;
  logic [1:0]  left_gain_out, right_gain_out;
  logic [2:0]  bias_select_out;
  int          n_errors = 0;
  int          num_checks = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  jack_widget_regs uut (.ref_clk(ref_clk), .resetn(resetn),
    .function_group_reset(function_group_reset), .link_reset(link_reset),
    .verb_valid(verb_valid), .verb_code(verb_code), .verb_payload(verb_payload),
    .jack_present_pin(jack_present_pin), .resp_valid(resp_valid), .resp_data(resp_data),
    .event_valid(event_valid), .event_data(event_data), .wake_req(wake_req),
    .amp_powerdown_pin(amp_powerdown_pin), .left_gain_out(left_gain_out),
    .right_gain_out(right_gain_out), .bias_select_out(bias_select_out),
    .receive_in_enable_out(receive_in_enable_out));
  link_ctrl_model ctl (.clk(ref_clk), .resp_valid(resp_valid), .resp_data(resp_data),
    .verb_valid(verb_valid), .verb_code(verb_code), .verb_payload(verb_payload));
  // verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // set verb; sets answer with zero data
  task automatic wr_verb(input logic [11:0] verb, input logic [7:0] pay);
    ctl.xfer({verb, 8'h00}, pay, d);
    `CHK(d, 32'h0)
  endtask : wr_verb
  // get verb compared against a whole word
  task automatic rd_chk(input logic [19:0] code, input logic [31:0] exp);
    ctl.xfer(code, 8'h00, d);
    `CHK(d, exp)
  endtask : rd_chk
  // capability, descriptor and power words after reset
  task automatic t_reset_values();
    rd_chk(WIDGET_CAPABILITY_WORD, 32'h400000 | 32'h400 | 32'h80 | 32'h3);
    rd_chk(JACK_CAPABILITY_WORD, 32'h10000 | (32'h17 << 8) | 32'h24);
    for (int i = 0; i < 4; i++)
      rd_chk(JACK_DESCRIPTOR + 20'(i << 8), DESC_EXP);
    rd_chk(AMP_POWERDOWN_CONTROL, 32'h2);
    rd_chk(JACK_PRESENCE_SENSE, 32'h0);
    rd_chk(POWER_STATE_WORD, 32'h430);
    rd_chk(POWER_STATE_WORD, 32'h030);
    `CHK(amp_powerdown_pin, 1'b0)
  endtask : t_reset_values
  // gain steps, upper payload bits dropped
  task automatic t_gain();
    wr_verb(VERB_SET_GAIN_LEFT, 8'hff);
    wr_verb(VERB_SET_GAIN_RIGHT, 8'h01);
    rd_chk(LEFT_INPUT_GAIN, 32'h3);
    rd_chk(RIGHT_INPUT_GAIN, 32'h1);
    `CHK(left_gain_out, 2'h3)
    `CHK(right_gain_out, 2'h1)
  endtask : t_gain
  // power setting, actual state and amplifier pin
  task automatic t_power();
    wr_verb(VERB_SET_POWER, 8'h00);
    rd_chk(POWER_STATE_WORD, 32'h0);
    `CHK(amp_powerdown_pin, 1'b1)
    wr_verb(VERB_SET_AMP_PD, 8'h00);
    rd_chk(AMP_POWERDOWN_CONTROL, 32'h0);
    `CHK(amp_powerdown_pin, 1'b0)
    wr_verb(VERB_SET_AMP_PD, 8'h03);
    rd_chk(AMP_POWERDOWN_CONTROL, 32'h2);
    wr_verb(VERB_SET_POWER, 8'h02);
    rd_chk(POWER_STATE_WORD, 32'h22);
    `CHK(amp_powerdown_pin, 1'b0)
  endtask : t_power
  // pin control byte and every bias code
  task automatic t_jack_ctrl();
    ctl.spacing = 3;
    wr_verb(VERB_SET_JACK_CTRL, 8'hfd);
    rd_chk(JACK_CONTROL_WORD, 32'h65);
    repeat (2) @(posedge ref_clk);
    `CHK(receive_in_enable_out, 1'b1)
    for (int c = 0; c < 8; c++)
    begin
      wr_verb(VERB_SET_JACK_CTRL, {5'h00, 3'(c)});
      repeat (2) @(posedge ref_clk);
      `CHK(bias_select_out, (c == 3 || c > 5) ? 3'h0 : 3'(c))
    end
    `CHK(receive_in_enable_out, 1'b0)
    ctl.spacing = 0;
  endtask : t_jack_ctrl
  // presence change with a bounded wait for an event
  task automatic pin_event(input logic lvl, input logic want);
    logic seen = 1'b0;
    @(posedge ref_clk);
    jack_present_pin <= lvl;
    repeat (10)
    begin
      @(posedge ref_clk);
      #1;
      if (event_valid === 1'b1)
      begin
        seen = 1'b1;
        `CHK(event_data[31:26], 6'h2a)
        `CHK(wake_req, 1'b1)
      end
    end
    `CHK(seen, want)
  endtask : pin_event
  // events enabled, disabled, then masked by the override flag
  task automatic t_event();
    wr_verb(VERB_SET_EVENT_CTRL, 8'hea);
    rd_chk(EVENT_REPORT_CONTROL, 32'haa);
    pin_event(1'b1, 1'b1);
    rd_chk(JACK_PRESENCE_SENSE, 32'h80000000);
    wr_verb(VERB_SET_EVENT_CTRL, 8'h2a);
    pin_event(1'b0, 1'b0);
    rd_chk(JACK_PRESENCE_SENSE, 32'h0);
    wr_verb(VERB_SET_DESC_B1, 8'h91);
    wr_verb(VERB_SET_EVENT_CTRL, 8'hea);
    pin_event(1'b1, 1'b0);
    rd_chk(JACK_PRESENCE_SENSE, 32'h0);
    wr_verb(VERB_SET_DESC_B1, 8'h90);
    rd_chk(JACK_PRESENCE_SENSE, 32'h80000000);
  endtask : t_event
  // group reset then link reset; descriptor survives both
  task automatic t_resets();
    for (int r = 0; r < 2; r++)
    begin
      wr_verb(VERB_SET_DESC_B0, 8'h5f);
      rd_chk(JACK_DESCRIPTOR, {DESC_EXP[31:8], 8'h5f});
      wr_verb(VERB_SET_GAIN_LEFT, 8'h02);
      @(posedge ref_clk);
      function_group_reset <= (r == 0);
      link_reset           <= (r == 1);
      repeat (6) @(posedge ref_clk);
      function_group_reset <= 1'b0;
      link_reset           <= 1'b0;
      repeat (4) @(posedge ref_clk);
      if (r == 1)
        wr_verb(12'h7ff, 8'h00);
      rd_chk(POWER_STATE_WORD, (r == 0) ? 32'h430 : 32'h030);
      rd_chk(LEFT_INPUT_GAIN, 32'h0);
      rd_chk(AMP_POWERDOWN_CONTROL, 32'h2);
      rd_chk(JACK_DESCRIPTOR, {DESC_EXP[31:8], 8'h5f});
    end
    rd_chk(20'hf0a00, 32'h0);
  endtask : t_resets
  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_gain();
    t_power();
    t_jack_ctrl();
    t_event();
    t_resets();
    summarize();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
